// ===== hw/t1bsc_ctrl.sv
// Bit-oriented code controller for the T1 facility data link
//
// Overview of operation
// [RULE1] Software loads the six-bit code first, then sets the send-code bit.
// [RULE2] Send-code bit low sends no code; high sends the low six transmit bits.
// [RULE3] Transmit word bits 6 and 7 are ignored while codes are sent.
// [RULE4] Filter bits pick 1, 3, 5 or 7 identical codes before validity.
// [RULE5] A rising edge of the receive reset bit resets the code receiver.
// [RULE6] Receive enable runs the detector; receive word then shows the code.
// [RULE7] Receive word bits 0-5 hold the code, bits 6 and 7 read zero; with receive enable low the word returns the last received data byte instead.
// [RULE8] Status bit 0 sets on each change to a newly valid code.
// [RULE9] Status bit 1 sets when the receive word equals either match register.
// [RULE10] Status bit 2 sets when the transmit buffer empties, bit 3 on receive full.
// [RULE11] Status bit 4 sets on eight consecutive received ones.
// [RULE12] Status bit 5 sets after thirty link bits without an abort.
// [RULE13] Mask bits 0-5 gate the same status bits; one allows the interrupt.
// [RULE14] Software writes zero to control bits 5 to 7.
// [RULE15] Software writes zero to mask bits 6 and 7.
// [RULE16] Receive flow: set filter, enable, unmask, await interrupt, read word.
// [RULE17] Code frame is zero, six code bits, zero, eight ones.
// [RULE18] Setting send-code starts the frame at once and repeats it.
// [RULE19] Received code reads all ones until a valid code arrives.
// [RULE20] Interrupt output is high while any unmasked status bit is set.
// [RULE21] Status bits stay set until software clears them.
`timescale 1ns/10ps
module t1bsc_ctrl
  import t1bsc_pkg::*;
#(
  parameter int ABORT_LEN = ABORT_ONES,
  parameter int CLEAR_LEN = CLEAR_BITS
) (
  input wire logic SYS_CLK, // 10 MHz system clock
  input wire logic RST, // Synchronous reset, active high
  input wire logic [7:0] ADDR, // Register address
  input wire logic [7:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  output logic [7:0] RDATA, // Read data, valid the cycle after RD
  input wire logic LINK_SLOT, // One-cycle pulse per data link bit slot
  input wire logic LINK_RX_BIT, // Received data link bit, sampled on LINK_SLOT
  output logic LINK_TX_BIT, // Transmitted data link bit
  output logic IRQ // Interrupt, active high
);
  if (ABORT_LEN < 2 || ABORT_LEN > 15) begin : g_chk_abort
    $error("ABORT_LEN out of range");
  end
  if (CLEAR_LEN < 2 || CLEAR_LEN > 31) begin : g_chk_clear
    $error("CLEAR_LEN out of range");
  end

  typedef struct packed {
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [CTL_W-1:0] ctrl;
    logic [7:0] tx_word;
    logic tx_full;
    logic [7:0] match_a;
    logic [7:0] match_b;
    logic [7:0] rdata;
    logic irq;
    logic tx_bit;
    t1bsc_txm_t txm;
    logic [4:0] tx_cnt;
    logic [PAT_W-1:0] tx_sh;
    logic [PAT_W-1:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [7:0] rx_byte;
    logic [3:0] ones;
    logic [4:0] quiet;
    logic quiet_done;
    logic rst_prev;
    logic ena_prev;
  } t1bsc_state_t;

  t1bsc_state_t r, next_r;

  logic restart;
  logic det;
  logic [PAT_W-1:0] rx_win;
  logic [CODE_W-1:0] flt_code;
  logic flt_change;
  logic [7:0] rx_word;

  // A detected code is the receive window shaped as a whole frame
  assign rx_win = {r.rx_sh[PAT_W-2:0], LINK_RX_BIT};
  assign det = LINK_SLOT && r.ctrl[CTL_RX_ENA] && !restart && rx_win[PAT_W-1] == 1'b0
    && rx_win[BYTE_W] == 1'b0 && rx_win[BYTE_W-1:0] == ABORT_BYTE; // [RULE6] [RULE17]
  assign restart = (r.ctrl[CTL_RX_RST] && !r.rst_prev)
    || (r.ctrl[CTL_RX_ENA] && !r.ena_prev); // [RULE5] [RULE19]
  assign rx_word = r.ctrl[CTL_RX_ENA] ? {2'b00, flt_code} : r.rx_byte; // [RULE7]

  t1bsc_filter u_filter (
    .clk(SYS_CLK),
    .rst(RST),
    .restart(restart),
    .det(det),
    .det_code(rx_win[PAT_W-2 -: CODE_W]),
    .need(flt_need({r.ctrl[CTL_FLT_HI], r.ctrl[CTL_FLT_LO]})),
    .code(flt_code),
    .change(flt_change)
  );

  always_comb begin
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic [PAT_W-1:0] word;
    logic [7:0] new_byte;
    ev = '0;
    clr = '0;
    word = '0;
    new_byte = {r.rx_sh[6:0], LINK_RX_BIT};
    next_r = r;
    next_r.rdata = REG_RESET;
    next_r.rst_prev = r.ctrl[CTL_RX_RST];
    next_r.ena_prev = r.ctrl[CTL_RX_ENA];

    // Transmit side
    if (LINK_SLOT) begin
      if (r.ctrl[CTL_SEND]) begin
        // Start a fresh frame on entry or after the last bit, so the first bit goes out at once
        if (r.txm != TXM_CODE || r.tx_cnt == 5'(PAT_W)) begin // [RULE18]
          word = code_frame(r.tx_word[CODE_W-1:0]); // [RULE2] [RULE3] [RULE17]
          next_r.tx_cnt = 5'h1;
        end else begin
          word = r.tx_sh;
          next_r.tx_cnt = r.tx_cnt + 5'h1;
        end
        next_r.tx_bit = word[PAT_W-1];
        next_r.tx_sh = {word[PAT_W-2:0], 1'b0};
        next_r.txm = TXM_CODE;
      end else if (r.txm == TXM_DATA && r.tx_cnt != 5'(BYTE_W)) begin
        next_r.tx_bit = r.tx_sh[PAT_W-1];
        next_r.tx_sh = {r.tx_sh[PAT_W-2:0], 1'b0};
        next_r.tx_cnt = r.tx_cnt + 5'h1;
      end else if (r.tx_full) begin
        next_r.tx_bit = r.tx_word[7];
        next_r.tx_sh = {r.tx_word[6:0], 9'h000};
        next_r.tx_cnt = 5'h1;
        next_r.tx_full = 1'b0;
        next_r.txm = TXM_DATA;
        ev[EV_TX_EMPTY] = 1'b1; // [RULE10]
      end else begin
        // Idle line carries ones; no code leaves while send-code is low
        next_r.tx_bit = 1'b1; // [RULE2]
        next_r.txm = TXM_IDLE;
      end
    end

    // Receive side
    if (restart) begin
      next_r.rx_sh = '0;
      next_r.rx_cnt = '0;
    end else if (LINK_SLOT) begin
      next_r.rx_sh = rx_win;
      if (LINK_RX_BIT) begin
        if (r.ones != 4'(ABORT_LEN)) begin
          next_r.ones = r.ones + 4'h1;
        end
        if (r.ones == 4'(ABORT_LEN - 1)) begin
          ev[EV_ABORT] = 1'b1; // [RULE11]
        end
      end else begin
        next_r.ones = '0;
      end
      if (ev[EV_ABORT]) begin
        next_r.quiet = '0;
        next_r.quiet_done = 1'b0;
      end else if (!r.quiet_done) begin
        if (r.quiet == 5'(CLEAR_LEN - 1)) begin
          ev[EV_CLEAR] = 1'b1; // [RULE12]
          next_r.quiet_done = 1'b1;
        end else begin
          next_r.quiet = r.quiet + 5'h1;
        end
      end
      if (!r.ctrl[CTL_RX_ENA]) begin
        next_r.rx_cnt = r.rx_cnt + 3'h1;
        if (r.rx_cnt == 3'(BYTE_W - 1)) begin
          next_r.rx_byte = new_byte;
          ev[EV_RX_FULL] = 1'b1; // [RULE10]
          ev[EV_MATCH] = new_byte == r.match_a || new_byte == r.match_b; // [RULE9]
        end
      end
    end
    if (flt_change) begin
      ev[EV_CODE] = 1'b1; // [RULE8]
      ev[EV_MATCH] = rx_word == r.match_a || rx_word == r.match_b; // [RULE9]
    end

    // Register writes
    if (WR) begin
      unique case (ADDR)
        OFF_STATUS: clr = WDATA[EV_W-1:0];
        OFF_MASK: next_r.mask = WDATA[EV_W-1:0]; // [RULE13] [RULE15]
        OFF_CTRL: next_r.ctrl = WDATA[CTL_W-1:0]; // [RULE14]
        OFF_TX_WORD: begin
          next_r.tx_word = WDATA; // [RULE1]
          next_r.tx_full = 1'b1;
        end
        OFF_MATCH_A: next_r.match_a = WDATA;
        OFF_MATCH_B: next_r.match_b = WDATA;
        default: ;
      endcase
    end

    // Register reads, unmapped addresses answer zero
    if (RD) begin
      unique case (ADDR)
        OFF_STATUS: next_r.rdata = {2'b00, r.status};
        OFF_MASK: next_r.rdata = {2'b00, r.mask};
        OFF_CTRL: next_r.rdata = {3'b000, r.ctrl};
        OFF_RX_WORD: next_r.rdata = rx_word; // [RULE6] [RULE16]
        OFF_TX_WORD: next_r.rdata = r.tx_word;
        OFF_MATCH_A: next_r.rdata = r.match_a;
        OFF_MATCH_B: next_r.rdata = r.match_b;
        default: next_r.rdata = REG_RESET;
      endcase
    end

    // Sticky status: a new event wins over a clear in the same cycle
    next_r.status = (r.status & ~clr) | ev; // [RULE21]
    next_r.irq = |(next_r.status & next_r.mask); // [RULE13] [RULE20]
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      r <= '{status: '0, mask: '0, ctrl: '0, tx_word: REG_RESET, tx_full: 1'b0,
        match_a: REG_RESET, match_b: REG_RESET, rdata: REG_RESET, irq: 1'b0,
        tx_bit: 1'b1, txm: TXM_IDLE, tx_cnt: '0, tx_sh: '0, rx_sh: '0, rx_cnt: '0,
        rx_byte: REG_RESET, ones: '0, quiet: '0, quiet_done: 1'b0, rst_prev: 1'b0,
        ena_prev: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign RDATA = r.rdata;
  assign LINK_TX_BIT = r.tx_bit;
  assign IRQ = r.irq;
endmodule

// ===== hw/t1bsc_pkg.sv
// Constants, register map and field layout of the T1 code controller
package t1bsc_pkg;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_MASK = 8'h25;
  localparam logic [7:0] OFF_CTRL = 8'h37;
  localparam logic [7:0] OFF_RX_WORD = 8'hc0;
  localparam logic [7:0] OFF_TX_WORD = 8'hc1;
  localparam logic [7:0] OFF_MATCH_A = 8'hc2;
  localparam logic [7:0] OFF_MATCH_B = 8'hc3;

  localparam int CTL_W = 5;
  localparam int CTL_SEND = 0;
  localparam int CTL_FLT_LO = 1;
  localparam int CTL_FLT_HI = 2;
  localparam int CTL_RX_RST = 3;
  localparam int CTL_RX_ENA = 4;

  localparam int EV_W = 6;
  localparam int EV_CODE = 0;
  localparam int EV_MATCH = 1;
  localparam int EV_TX_EMPTY = 2;
  localparam int EV_RX_FULL = 3;
  localparam int EV_ABORT = 4;
  localparam int EV_CLEAR = 5;

  localparam int CODE_W = 6;
  localparam int PAT_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [CODE_W-1:0] CODE_PRESET = 6'h3f;
  localparam logic [7:0] ABORT_BYTE = 8'hff;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam int FLT_CNT_W = 3;
  localparam logic [FLT_CNT_W-1:0] FLT_NONE = 3'h1;
  localparam logic [FLT_CNT_W-1:0] FLT_THREE = 3'h3;
  localparam logic [FLT_CNT_W-1:0] FLT_FIVE = 3'h5;
  localparam logic [FLT_CNT_W-1:0] FLT_SEVEN = 3'h7;

  localparam int ABORT_ONES = 8;
  localparam int CLEAR_BITS = 30;

  typedef enum logic [2:0] {
    TXM_IDLE = 3'b001,
    TXM_DATA = 3'b010,
    TXM_CODE = 3'b100
  } t1bsc_txm_t;

  // Identical codes needed before a code counts as valid; "none" still needs one sighting
  function automatic logic [FLT_CNT_W-1:0] flt_need(input logic [1:0] sel);
    unique case (sel)
      2'b00: flt_need = FLT_NONE;
      2'b01: flt_need = FLT_THREE;
      2'b10: flt_need = FLT_FIVE;
      2'b11: flt_need = FLT_SEVEN;
    endcase
  endfunction

  // Framed code: zero, six code bits, zero, then the abort byte; sent from the top bit down
  function automatic logic [PAT_W-1:0] code_frame(input logic [CODE_W-1:0] code);
    code_frame = {1'b0, code, 1'b0, ABORT_BYTE};
  endfunction
endpackage

// ===== hw/t1bsc_filter.sv
// Receive code integration filter: counts consecutive identical codes
`timescale 1ns/10ps
module t1bsc_filter
  import t1bsc_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic restart, // Receive code reset pulse
  input wire logic det, // One framed code seen this cycle
  input wire logic [CODE_W-1:0] det_code, // Code seen
  input wire logic [FLT_CNT_W-1:0] need, // Repetitions required
  output logic [CODE_W-1:0] code, // Last valid code
  output logic change // One-cycle pulse on a new valid code
);
  typedef struct packed {
    logic [CODE_W-1:0] cand;
    logic [FLT_CNT_W-1:0] cnt;
    logic [CODE_W-1:0] code;
    logic change;
  } t1bsc_flt_t;

  t1bsc_flt_t r, next_r;

  always_comb begin
    next_r = r;
    next_r.change = 1'b0;
    if (restart) begin
      next_r.cand = CODE_PRESET; // [RULE5]
      next_r.cnt = '0;
      next_r.code = CODE_PRESET; // [RULE19]
    end else if (det) begin
      if (det_code == r.cand && r.cnt != '0) begin
        // Saturate so a long run does not wrap and look fresh
        if (r.cnt != FLT_SEVEN) begin
          next_r.cnt = r.cnt + 3'h1;
        end
      end else begin
        next_r.cand = det_code;
        next_r.cnt = 3'h1;
      end
      if (next_r.cnt == need && next_r.cand != r.code) begin // [RULE4]
        next_r.code = next_r.cand;
        next_r.change = 1'b1; // [RULE8]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{cand: CODE_PRESET, cnt: '0, code: CODE_PRESET, change: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign code = r.code;
  assign change = r.change;
endmodule

// ===== verif/t1bsc_ctrl_asserts.sv
// Port assertions for the T1 code controller
`timescale 1ns/10ps
module t1bsc_ctrl_asserts
  import t1bsc_pkg::*;
#(
  parameter int ABORT_LEN = ABORT_ONES,
  parameter int CLEAR_LEN = CLEAR_BITS
) (
  input wire logic SYS_CLK, // Clock
  input wire logic RST, // Reset
  input wire logic [7:0] ADDR, // Address
  input wire logic [7:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  input wire logic [7:0] RDATA, // Read data
  input wire logic LINK_SLOT, // Bit slot
  input wire logic LINK_RX_BIT, // Received bit
  input wire logic LINK_TX_BIT, // Sent bit
  input wire logic IRQ // Interrupt
);
  logic [EV_W-1:0] mask;
  logic [CTL_W-1:0] ctl;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // Shadows follow the bus so readback can be judged without the body
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mask <= '0;
      ctl <= '0;
    end else begin
      if (WR && ADDR == OFF_MASK)
        mask <= WDATA[EV_W-1:0];
      if (WR && ADDR == OFF_CTRL)
        ctl <= WDATA[CTL_W-1:0];
    end
  end
  chk_tx_holds: assert property (!LINK_SLOT |=> $stable(LINK_TX_BIT))
    else $error("tx bit moved outside a slot");
  chk_irq_rise: assert property ($rose(IRQ) |-> $past(LINK_SLOT) || $past(LINK_SLOT, 2) || $past(WR))
    else $error("irq rose without cause");
  chk_irq_fall: assert property ($fell(IRQ) |-> $past(WR))
    else $error("irq fell without a write");
  chk_mask_read: assert property (RD && ADDR == OFF_MASK |=> RDATA == {2'h0, mask})
    else $error("mask readback wrong");
  chk_mask_blocks: assert property (mask == '0 && !WR |=> !IRQ)
    else $error("irq with all events masked");
  chk_ctl_read: assert property (RD && ADDR == OFF_CTRL |=> RDATA == {3'h0, ctl})
    else $error("control readback wrong");
  chk_rx_hi_zero: assert property (RD && ADDR == OFF_RX_WORD && ctl[CTL_RX_ENA] |=> RDATA[7:6] == 2'h0)
    else $error("rx word upper bits set");
  chk_unmapped_zero: assert property (RD && ADDR == 8'h00 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data outside its cycle");
endmodule

// ===== verif/t1bsc_remote.sv
// Far-end T1 equipment: bit slot timing and bursts of code frames
`timescale 1ns/10ps
module t1bsc_remote
  import t1bsc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic slot_en, // Let bit slots run
  input wire logic load, // Start a burst
  input wire logic [CODE_W-1:0] code, // Code to send
  input wire logic [3:0] frames, // Frames in the burst
  output logic slot, // One-cycle bit slot
  output logic rx_bit, // Line bit toward the device
  output logic busy // Burst in progress
);
  logic [1:0] div;
  logic [3:0] idx;
  logic [3:0] left;
  logic [PAT_W-1:0] pat;
  assign busy = left != 4'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      div <= 2'h0;
      idx <= 4'h0;
      left <= 4'h0;
      pat <= '0;
      slot <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      div <= div + 2'h1;
      slot <= slot_en && div == 2'h3;
      if (load) begin
        left <= frames;
        pat <= {1'b0, code, 1'b0, 8'hff};
        idx <= 4'h0;
      end else if (slot_en && div == 2'h3) begin
        // Idle line is zeros so no stray abort or frame appears between bursts
        rx_bit <= busy && pat[4'hf - idx];
        if (busy) begin
          idx <= idx + 4'h1;
          if (idx == 4'hf)
            left <= left - 4'h1;
        end
      end
    end
  end
endmodule

// ===== verif/test_t1_boc_ssm_controller.sv
// Self-checking bench for the T1 code controller
`timescale 1ns/10ps
module test_t1_boc_ssm_controller;
  import t1bsc_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} t1bsc_row_t;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [7:0] RDATA;
  logic LINK_SLOT, LINK_RX_BIT, LINK_TX_BIT, IRQ, busy;
  logic slot_en = 1'b0;
  logic load = 1'b0;
  logic [5:0] code = 6'h00;
  logic [3:0] frames = 4'h0;
  int n_mismatch = 0;
  int check_count = 0;
  logic [7:0] d;
  logic [15:0] txw;
  logic [5:0] codes [4] = '{6'h02, 6'h11, 6'h18, 6'h08};
  t1bsc_row_t rows [8] = '{'{OFF_MASK, 8'h15, 8'h15}, '{OFF_MASK, 8'h3f, 8'h3f}, '{OFF_MATCH_A, 8'h11, 8'h11},
    '{OFF_MATCH_B, 8'h34, 8'h34}, '{OFF_RX_WORD, 8'haa, 8'h00}, '{OFF_STATUS, 8'h3f, 8'h00},
    '{8'h00, 8'h55, 8'h00}, '{OFF_CTRL, 8'h06, 8'h06}};
  t1bsc_ctrl i_dut(.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .LINK_SLOT(LINK_SLOT), .LINK_RX_BIT(LINK_RX_BIT), .LINK_TX_BIT(LINK_TX_BIT), .IRQ(IRQ));
  t1bsc_remote i_far(.clk(SYS_CLK), .rst(RST), .slot_en(slot_en), .load(load), .code(code), .frames(frames),
    .slot(LINK_SLOT), .rx_bit(LINK_RX_BIT), .busy(busy));
  initial begin
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    n_mismatch++;
    $display("unexpected wait %s: expected end seen timeout", nm);
    give_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= w;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic send(input logic [5:0] c, input logic [3:0] n);
    int i;
    @(posedge SYS_CLK);
    code <= c;
    frames <= n;
    load <= 1'b1;
    @(posedge SYS_CLK);
    load <= 1'b0;
    for (i = 0; i < 2000 && (busy !== 1'b0 || i < 2); i++)
      @(posedge SYS_CLK);
    if (busy !== 1'b0)
      hang("burst");
    repeat (4) @(posedge SYS_CLK);
  endtask
  task automatic get_bit(output logic b);
    int i;
    i = 0;
    do begin
      @(posedge SYS_CLK);
      #1;
      i++;
    end while (LINK_SLOT !== 1'b1 && i < 20);
    if (i >= 20)
      hang("slot");
    @(posedge SYS_CLK);
    #1 b = LINK_TX_BIT;
  endtask
  initial begin
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    foreach (rows[k]) begin
      rd(rows[k].a);
      chk8("reset value", REG_RESET, d);
    end
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].w);
      rd(rows[k].a);
      chk8("readback", rows[k].r, d);
    end
    slot_en <= 1'b1;
    wr(OFF_STATUS, 8'h3f);
    wr(OFF_TX_WORD, 8'h5a);
    repeat (48) @(posedge SYS_CLK);
    rd(OFF_STATUS);
    chk8("buffer events", 8'h0c, d & 8'h0c);
    slot_en <= 1'b0;
    // Slots held off so the frame start can be pinned to the first slot
    wr(OFF_TX_WORD, 8'hc4);
    wr(OFF_CTRL, 8'h01);
    slot_en <= 1'b1;
    repeat (2) begin
      for (int k = 15; k >= 0; k--)
        get_bit(txw[k]);
      chk8("frame head", {1'b0, 6'h04, 1'b0}, txw[15:8]);
      chk8("frame tail", 8'hff, txw[7:0]);
    end
    slot_en <= 1'b0;
    wr(OFF_CTRL, 8'h00);
    slot_en <= 1'b1;
    for (int k = 15; k >= 0; k--)
      get_bit(txw[k]);
    chk1("code stopped", 1'b1, txw !== {1'b0, 6'h04, 1'b0, 8'hff});
    // The word written while codes were off is still pending, so it leaves as data once send-code drops
    chk8("pending data", 8'hc4, txw[15:8]);
    chk8("idle ones", 8'hff, txw[7:0]);
    wr(OFF_MASK, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CTRL, 8'(2 * s));
      wr(OFF_CTRL, 8'(2 * s + 16));
      rd(OFF_RX_WORD);
      chk8("preset", {2'h0, CODE_PRESET}, d);
      wr(OFF_STATUS, 8'h3f);
      if (s > 0)
        send(codes[s], 4'(2 * s));
      rd(OFF_STATUS);
      chk8("early status", 8'h00, d & 8'h01);
      chk1("early irq", 1'b0, IRQ);
      send(codes[s], 4'h1);
      chk1("irq", 1'b1, IRQ);
      rd(OFF_STATUS);
      chk8("status", {3'h0, 1'b1, 2'h0, codes[s] == 6'h11, 1'b1}, d & 8'h13);
      rd(OFF_RX_WORD);
      chk8("rx code", {2'h0, codes[s]}, d);
      wr(OFF_CTRL, 8'h00);
    end
    wr(OFF_CTRL, 8'h12);
    wr(OFF_STATUS, 8'h3f);
    send(6'h14, 4'h2);
    wr(OFF_CTRL, 8'h1a);
    wr(OFF_CTRL, 8'h12);
    send(6'h14, 4'h2);
    rd(OFF_STATUS);
    chk8("restarted", 8'h00, d & 8'h01);
    send(6'h14, 4'h1);
    rd(OFF_STATUS);
    chk8("recounted", 8'h01, d & 8'h01);
    wr(OFF_STATUS, 8'h3f);
    repeat (144) @(posedge SYS_CLK);
    rd(OFF_STATUS);
    chk8("quiet line", 8'h20, d & 8'h30);
    chk1("irq masked", 1'b0, IRQ);
    wr(OFF_MASK, 8'h20);
    #1 chk1("irq unmasked", 1'b1, IRQ);
    wr(OFF_MASK, 8'h00);
    #1 chk1("irq blocked", 1'b0, IRQ);
    wr(OFF_MASK, 8'h20);
    wr(OFF_CTRL, 8'h13);
    // Reset in mid-run with an interrupt pending and codes going out; slots held off so no event refills status
    @(posedge SYS_CLK);
    RST <= 1'b1;
    slot_en <= 1'b0;
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    #1;
    chk1("irq after reset", 1'b0, IRQ);
    chk1("tx after reset", 1'b1, LINK_TX_BIT);
    chk8("rdata after reset", 8'h00, RDATA);
    foreach (rows[k]) begin
      rd(rows[k].a);
      chk8("reset value", REG_RESET, d);
    end
    give_verdict();
  end
endmodule
bind t1bsc_ctrl t1bsc_ctrl_asserts #(.ABORT_LEN(ABORT_LEN), .CLEAR_LEN(CLEAR_LEN)) i_chk(.SYS_CLK(SYS_CLK),
  .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LINK_SLOT(LINK_SLOT),
  .LINK_RX_BIT(LINK_RX_BIT), .LINK_TX_BIT(LINK_TX_BIT), .IRQ(IRQ));
